// [charger_defines.svh]
// constants for the charger fault and thermal controller
`ifndef CHARGER_DEFINES_SVH
`define CHARGER_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CTRL_ADDR 8'h00
`define THRESH_ADDR 8'h04
`define TARGET_ADDR 8'h08
`define ALT_ADDR 8'h0C
`define STATUS_ADDR 8'h10
`define IRQ_FLAG_ADDR 8'h14
`define IRQ_MASK_ADDR 8'h18

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CTRL_RESET 7'h00
`define THRESH_RESET 8'h00
`define CV_RESET 6'h00
`define SYS_RESET 6'h3F
`define CC_RESET 6'h00

// ------------------------------------------------------------
// status field codes
// ------------------------------------------------------------
`define ST_OFF 4'h0
`define ST_PREQ 4'h1
`define ST_CC 4'h2
`define ST_CV 4'h3
`define ST_TOPOFF 4'h4
`define ST_DONE 4'h5
`define ST_ALT_CC 4'h6
`define ST_ALT_CV 4'h7
`define ST_ALT_TOPOFF 4'h8
`define ST_PQ_FAULT 4'h9
`define ST_FC_FAULT 4'hA
`define ST_TEMP_FAULT 4'hB
`define ZONE_OFF 3'h0
`define ZONE_COLD 3'h1
`define ZONE_COOL 3'h2
`define ZONE_NORMAL 3'h3
`define ZONE_WARM 3'h4
`define ZONE_HOT 3'h5

// ------------------------------------------------------------
// interrupt flag positions
// ------------------------------------------------------------
`define IRQ_CHG_BIT 0
`define IRQ_THM_BIT 1
`define IRQ_SYS_BIT 2

// ------------------------------------------------------------
// timing and voltage figures
// ------------------------------------------------------------
`define CLK_HZ 200000000
`define TICK_S 1
`define TICK_CYCLES (`CLK_HZ * `TICK_S)
`define PQ_TIME_MIN 30
`define PQ_TIME_S (`PQ_TIME_MIN * 60)
`define FC_STEP_H 2
`define FC_BASE_H 1
`define TOPOFF_STEP_MIN 5
`define CV_STEP_MV 25
`define SYS_MARGIN_MV 200
`define SYS_MARGIN_CODES 7'(`SYS_MARGIN_MV / `CV_STEP_MV)
`define SYNC_W 16

`endif

// [charger_pkg.sv]
// types for the charger fault and thermal controller
package charger_pkg;

  typedef enum logic [3:0] {
    S_OFF = 4'b0000,
    S_PREQ = 4'b0001,
    S_CC = 4'b0010,
    S_CV = 4'b0011,
    S_TOPOFF = 4'b0100,
    S_DONE = 4'b0101,
    S_PQ_FAULT = 4'b0110,
    S_FC_FAULT = 4'b0111,
    S_TEMP_FAULT = 4'b1000
  } chg_state_t;

  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
  } sync_state_t;

  typedef struct packed {
    logic [27:0] pre;
    logic [14:0] sec;
  } timer_state_t;

  typedef struct packed {
    chg_state_t state;
    chg_state_t saved;
    logic charge_enable_bit;
    logic thermistor_monitor_enable;
    logic [1:0] fc_timer_sel;
    logic [2:0] topoff_sel;
    logic [1:0] hot_threshold_sel;
    logic [1:0] warm_threshold_sel;
    logic [1:0] cool_threshold_sel;
    logic [1:0] cold_threshold_sel;
    logic [5:0] cv_voltage_setting;
    logic [5:0] sys_voltage_setting;
    logic [5:0] cc_current_setting;
    logic [5:0] alt_cc_current_setting;
    logic [5:0] alt_cv_voltage_setting;
    logic [3:0] charger_state_status;
    logic [2:0] temperature_zone_status;
    logic [2:0] irq_flags;
    logic [2:0] irq_mask;
    logic irq;
    logic ack;
    logic [31:0] dat;
    logic charge_on;
    logic batt_connect;
    logic [5:0] current_target;
    logic [5:0] voltage_target;
  } main_state_t;

endpackage

// [charge_timer_if.sv]
// control and count between state machine and charge timer
`timescale 1ns/1ps
`default_nettype none

interface charge_timer_if;
  logic clear;
  logic run;
  logic [14:0] seconds;
  modport ctrl (output clear, output run, input seconds);
  modport timer (input clear, input run, output seconds);
endinterface

`default_nettype wire

// [comparator_sync.sv]
// two-stage synchroniser for comparator outputs
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.svh"

module comparator_sync
  import charger_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`SYNC_W-1:0] async_i,
  output logic [`SYNC_W-1:0] sync_o
);
  sync_state_t st_reg;
  sync_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_i;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.s2;
endmodule

`default_nettype wire

// [charge_timer.sv]
// seconds counter shared by the charge timers, freezable
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.svh"

module charge_timer
  import charger_pkg::*;
#(
  parameter logic [27:0] TICK_CYCLES = 28'(`TICK_CYCLES)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  charge_timer_if.timer tmr
);
  timer_state_t st_reg;
  timer_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (tmr.clear) begin
      st_next.pre = '0;
      st_next.sec = '0;
    end else if (tmr.run) begin
      if (st_reg.pre == TICK_CYCLES - 28'h0000001) begin
        st_next.pre = '0;
        if (st_reg.sec != 15'h7FFF) begin
          st_next.sec = st_reg.sec + 15'h0001;
        end
      end else begin
        st_next.pre = st_reg.pre + 28'h0000001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tmr.seconds = st_reg.sec;
endmodule

`default_nettype wire

// [charger_fault_thermal_fsm.sv]
// charger state machine with timer faults, temperature faults and modified states
// ------------------------------------------------------------
// Overview of operation
// R1: prequal over 30 minutes enters timer fault
// R2: faults stop current, battery disconnected
// R3: timer faults left only via enable or input
// R4: fast-charge timer expiry enters timer fault
// R5: hot or cold enters temperature fault
// R6: temperature fault has priority, exits when cleared
// R7: resume previous state after temperature fault
// R8: timers frozen during temperature fault
// R9: warm or cool enters modified states
// R10: modified states use alternate targets
// R11: leave modified states when normal or disabled
// R12: normal band uses normal targets
// R13: zone status field, interrupt on change
// R14: enforce system margin, lower cv, interrupt
// R15: software programs four threshold codes
// R16: classify temperature continuously when enabled
// R17: state status field, interrupt on change
// R18: enable low holds charger off
// R19: synchronise comparators before use
// ------------------------------------------------------------
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.svh"

module charger_fault_thermal_fsm
  import charger_pkg::*;
#(
  parameter logic [27:0] TICK_CYCLES = 28'(`TICK_CYCLES)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic chgin_valid_i,
  input wire logic batt_above_pq_i,
  input wire logic batt_at_cv_i,
  input wire logic batt_below_iterm_i,
  input wire logic batt_restart_i,
  input wire logic [3:0] hot_threshold_sel_cmp_i,
  input wire logic [3:0] warm_threshold_sel_cmp_i,
  input wire logic [3:0] cool_threshold_sel_cmp_i,
  input wire logic [3:0] cold_threshold_sel_cmp_i,
  output logic charge_on_o,
  output logic batt_connect_o,
  output logic [5:0] current_target_o,
  output logic [5:0] voltage_target_o,
  output logic irq_o
);
  // ------------------------------------------------------------
  // comparator synchronisation and timer
  // ------------------------------------------------------------
  logic [`SYNC_W-1:0] cmp_sync;
  charge_timer_if tmr ();

  comparator_sync u_sync ( // R19
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({cold_threshold_sel_cmp_i, cool_threshold_sel_cmp_i, warm_threshold_sel_cmp_i, hot_threshold_sel_cmp_i}),
    .sync_o(cmp_sync)
  );

  charge_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tmr(tmr)
  );

  main_state_t st_reg;
  main_state_t st_next;

  // ------------------------------------------------------------
  // temperature classification
  // ------------------------------------------------------------
  logic hot_hit;
  logic warm_hit;
  logic cool_hit;
  logic cold_hit;
  logic temp_fault;
  logic alt_mode;
  logic [2:0] zone;

  always_comb begin
    hot_hit = cmp_sync[st_reg.hot_threshold_sel]; // R5
    warm_hit = cmp_sync[4 + 32'(st_reg.warm_threshold_sel)];
    cool_hit = cmp_sync[8 + 32'(st_reg.cool_threshold_sel)];
    cold_hit = cmp_sync[12 + 32'(st_reg.cold_threshold_sel)]; // R5

    // extremes fault, mild bands modify targets
    temp_fault = st_reg.thermistor_monitor_enable && (hot_hit || cold_hit); // R5 R6
    alt_mode = st_reg.thermistor_monitor_enable && (warm_hit || cool_hit); // R9 R11 R12

    // zone code, extremes ahead of mild bands
    if (!st_reg.thermistor_monitor_enable) begin // R16
      zone = `ZONE_OFF;
    end else if (cold_hit) begin
      zone = `ZONE_COLD;
    end else if (hot_hit) begin
      zone = `ZONE_HOT;
    end else if (cool_hit) begin
      zone = `ZONE_COOL;
    end else if (warm_hit) begin
      zone = `ZONE_WARM;
    end else begin
      zone = `ZONE_NORMAL;
    end
  end

  // ------------------------------------------------------------
  // timer limits
  // ------------------------------------------------------------
  logic fc_expired;
  logic pq_expired;
  logic to_expired;
  logic [14:0] fc_limit;
  logic [14:0] to_limit;

  always_comb begin
    fc_limit = 15'((`FC_BASE_H + `FC_STEP_H * 32'(st_reg.fc_timer_sel)) * 3600);
    to_limit = 15'(`TOPOFF_STEP_MIN * 60 * 32'(st_reg.topoff_sel));

    // expiry flags, fast timer off at code 0
    fc_expired = (st_reg.fc_timer_sel != 2'h0) && (tmr.seconds >= fc_limit);
    pq_expired = tmr.seconds >= 15'(`PQ_TIME_S);
    to_expired = tmr.seconds >= to_limit;
  end

  // ------------------------------------------------------------
  // state machine, registers and bus
  // ------------------------------------------------------------
  logic wr;
  logic rd_cycle;
  logic [31:0] rdata;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [6:0] sys_ext;
  logic [6:0] cv_ext;
  logic [3:0] status;

  always_comb begin
    st_next = st_reg;
    tmr.clear = 1'b0;
    irq_set = 3'h0;
    irq_clr = 3'h0;
    // one-cycle ack, not re-taken while it stands
    rd_cycle = wb_cyc_i && wb_stb_i && !st_reg.ack;
    wr = rd_cycle && wb_we_i;
    st_next.ack = rd_cycle;

    // register writes
    if (wr && wb_sel_i[0]) begin
      case (wb_adr_i)
        `CTRL_ADDR: begin
          st_next.charge_enable_bit = wb_dat_i[0];
          st_next.thermistor_monitor_enable = wb_dat_i[1];
          st_next.fc_timer_sel = wb_dat_i[3:2];
          st_next.topoff_sel = wb_dat_i[6:4];
        end
        `THRESH_ADDR: begin // R15
          st_next.hot_threshold_sel = wb_dat_i[1:0];
          st_next.warm_threshold_sel = wb_dat_i[3:2];
          st_next.cool_threshold_sel = wb_dat_i[5:4];
          st_next.cold_threshold_sel = wb_dat_i[7:6];
        end
        `TARGET_ADDR: st_next.cv_voltage_setting = wb_dat_i[5:0];
        `ALT_ADDR: st_next.alt_cc_current_setting = wb_dat_i[5:0];
        `IRQ_FLAG_ADDR: irq_clr = wb_dat_i[2:0];
        `IRQ_MASK_ADDR: st_next.irq_mask = wb_dat_i[2:0];
        default: begin
        end
      endcase
    end
    if (wr && wb_sel_i[1]) begin
      case (wb_adr_i)
        `TARGET_ADDR: st_next.sys_voltage_setting = wb_dat_i[13:8];
        `ALT_ADDR: st_next.alt_cv_voltage_setting = wb_dat_i[13:8];
        default: begin
        end
      endcase
    end
    if (wr && wb_sel_i[2] && wb_adr_i == `TARGET_ADDR) begin
      st_next.cc_current_setting = wb_dat_i[21:16];
    end

    // system voltage margin check
    sys_ext = {1'b0, st_next.sys_voltage_setting};
    cv_ext = {1'b0, st_next.cv_voltage_setting};
    if (cv_ext + `SYS_MARGIN_CODES > sys_ext) begin // R14
      st_next.cv_voltage_setting = (sys_ext >= `SYS_MARGIN_CODES) ?
        6'(sys_ext - `SYS_MARGIN_CODES) : 6'h00;
      irq_set[`IRQ_SYS_BIT] = 1'b1;
    end

    // charger state transitions
    if (!st_reg.charge_enable_bit || !chgin_valid_i) begin // R18 R3
      st_next.state = S_OFF;
    end else if (temp_fault && st_reg.state != S_TEMP_FAULT && st_reg.state != S_OFF) begin
      st_next.saved = st_reg.state; // R6 R7
      st_next.state = S_TEMP_FAULT;
    end else begin
      // normal charge progression
      case (st_reg.state)
        S_OFF: begin
          tmr.clear = 1'b1;
          st_next.state = batt_above_pq_i ? S_CC : S_PREQ;
        end
        S_PREQ: begin
          if (batt_above_pq_i) begin
            tmr.clear = 1'b1;
            st_next.state = S_CC;
          end else if (pq_expired) begin
            st_next.state = S_PQ_FAULT; // R1
          end
        end
        S_CC: begin
          if (fc_expired) begin
            st_next.state = S_FC_FAULT; // R4
          end else if (batt_at_cv_i) begin
            st_next.state = S_CV;
          end
        end
        S_CV: begin
          if (fc_expired) begin
            st_next.state = S_FC_FAULT; // R4
          end else if (batt_below_iterm_i) begin
            tmr.clear = 1'b1;
            st_next.state = S_TOPOFF;
          end
        end
        S_TOPOFF: begin
          if (to_expired) begin
            st_next.state = S_DONE;
          end
        end
        S_DONE: begin
          if (batt_restart_i) begin
            tmr.clear = 1'b1;
            st_next.state = S_CC;
          end
        end
        // timer faults hold until enable or input drops
        S_PQ_FAULT: st_next.state = S_PQ_FAULT; // R3
        S_FC_FAULT: st_next.state = S_FC_FAULT; // R3
        S_TEMP_FAULT: begin
          if (!temp_fault) begin
            st_next.state = st_reg.saved; // R6 R7
          end
        end
        default: st_next.state = S_OFF;
      endcase
    end

    // timers count only in charging states, so they hold in the fault
    tmr.run = (st_reg.state == S_PREQ) || (st_reg.state == S_CC) ||
      (st_reg.state == S_CV) || (st_reg.state == S_TOPOFF); // R8

    // reported state
    case (st_next.state)
      S_OFF: status = `ST_OFF;
      S_PREQ: status = `ST_PREQ;
      S_CC: status = alt_mode ? `ST_ALT_CC : `ST_CC; // R9 R11
      S_CV: status = alt_mode ? `ST_ALT_CV : `ST_CV;
      S_TOPOFF: status = alt_mode ? `ST_ALT_TOPOFF : `ST_TOPOFF;
      S_DONE: status = `ST_DONE;
      S_PQ_FAULT: status = `ST_PQ_FAULT;
      S_FC_FAULT: status = `ST_FC_FAULT;
      S_TEMP_FAULT: status = `ST_TEMP_FAULT;
      default: status = `ST_OFF;
    endcase
    st_next.charger_state_status = status; // R17
    if (status != st_reg.charger_state_status) begin
      irq_set[`IRQ_CHG_BIT] = 1'b1; // R17
    end
    st_next.temperature_zone_status = zone; // R13
    if (zone != st_reg.temperature_zone_status) begin
      irq_set[`IRQ_THM_BIT] = 1'b1; // R13
    end

    // set wins over a clear in the same cycle
    st_next.irq_flags = (st_reg.irq_flags & ~irq_clr) | irq_set;
    st_next.irq = |(st_next.irq_flags & st_next.irq_mask);

    // charge outputs
    st_next.charge_on = (st_next.state == S_PREQ) || (st_next.state == S_CC) ||
      (st_next.state == S_CV) || (st_next.state == S_TOPOFF); // R2
    st_next.batt_connect = st_next.charge_on ||
      (st_next.state == S_OFF && !chgin_valid_i); // R2
    st_next.current_target = alt_mode ? st_next.alt_cc_current_setting :
      st_next.cc_current_setting; // R10 R12
    st_next.voltage_target = alt_mode ? st_next.alt_cv_voltage_setting :
      st_next.cv_voltage_setting; // R10 R12

    // read data
    case (wb_adr_i)
      `CTRL_ADDR: rdata = {25'h0, st_reg.topoff_sel, st_reg.fc_timer_sel,
        st_reg.thermistor_monitor_enable, st_reg.charge_enable_bit};
      `THRESH_ADDR: rdata = {24'h0, st_reg.cold_threshold_sel, st_reg.cool_threshold_sel,
        st_reg.warm_threshold_sel, st_reg.hot_threshold_sel};
      `TARGET_ADDR: rdata = {10'h0, st_reg.cc_current_setting, 2'h0,
        st_reg.sys_voltage_setting, 2'h0, st_reg.cv_voltage_setting};
      `ALT_ADDR: rdata = {18'h0, st_reg.alt_cv_voltage_setting, 2'h0,
        st_reg.alt_cc_current_setting};
      `STATUS_ADDR: rdata = {25'h0, st_reg.temperature_zone_status,
        st_reg.charger_state_status};
      `IRQ_FLAG_ADDR: rdata = {29'h0, st_reg.irq_flags};
      `IRQ_MASK_ADDR: rdata = {29'h0, st_reg.irq_mask};
      default: rdata = 32'h00000000;
    endcase
    st_next.dat = (rd_cycle && !wb_we_i) ? rdata : 32'h00000000;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.state <= S_OFF;
      st_reg.saved <= S_OFF;
      st_reg.sys_voltage_setting <= `SYS_RESET;
      st_reg.temperature_zone_status <= `ZONE_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o = st_reg.dat;
  assign wb_ack_o = st_reg.ack;

  assign charge_on_o = st_reg.charge_on;
  assign batt_connect_o = st_reg.batt_connect;
  assign current_target_o = st_reg.current_target;
  assign voltage_target_o = st_reg.voltage_target;
  assign irq_o = st_reg.irq;
endmodule

`default_nettype wire

// [charger_fault_thermal_fsm_properties.sv]
// concurrent checks on the charger controller ports
`timescale 1ns/1ps
`default_nettype none

module charger_fault_thermal_fsm_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic chgin_valid_i,
  input wire logic batt_above_pq_i,
  input wire logic [3:0] hot_threshold_sel_cmp_i,
  input wire logic [3:0] warm_threshold_sel_cmp_i,
  input wire logic [3:0] cool_threshold_sel_cmp_i,
  input wire logic [3:0] cold_threshold_sel_cmp_i,
  input wire logic charge_on_o,
  input wire logic batt_connect_o,
  input wire logic [5:0] current_target_o,
  input wire logic [5:0] voltage_target_o
);
  // ----------------------------------------
  // shadow of written settings
  // ----------------------------------------
  logic [1:0] ctrl_reg;
  logic [5:0] cc_reg;
  logic [5:0] sys_reg;
  logic [5:0] alt_cc_reg;
  logic [5:0] alt_cv_reg;
  logic wr;
  logic ext;
  logic mild;
  logic norm;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign ext = (&hot_threshold_sel_cmp_i) || (&cold_threshold_sel_cmp_i);
  assign mild = ((&warm_threshold_sel_cmp_i) || (&cool_threshold_sel_cmp_i)) && !ext;
  assign norm = !(|{hot_threshold_sel_cmp_i, warm_threshold_sel_cmp_i, cool_threshold_sel_cmp_i, cold_threshold_sel_cmp_i});
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= 2'h0;
      cc_reg <= 6'h00;
      sys_reg <= 6'h3F;
      alt_cc_reg <= 6'h00;
      alt_cv_reg <= 6'h00;
    end else if (wr) begin
      if (wb_adr_i == 8'h00) ctrl_reg <= wb_dat_i[1:0];
      if (wb_adr_i == 8'h08) cc_reg <= wb_dat_i[21:16];
      if (wb_adr_i == 8'h08) sys_reg <= wb_dat_i[13:8];
      if (wb_adr_i == 8'h0C) alt_cc_reg <= wb_dat_i[5:0];
      if (wb_adr_i == 8'h0C) alt_cv_reg <= wb_dat_i[13:8];
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data without ack");
  temp_fault_a: assert property (
    (ctrl_reg == 2'h3 && ext && chgin_valid_i)[*6] |-> !charge_on_o && !batt_connect_o)
    else $error("charging while battery too hot or cold");
  enable_off_a: assert property ((!ctrl_reg[0])[*4] |-> !charge_on_o)
    else $error("charging while disabled");
  alt_target_a: assert property (
    (ctrl_reg == 2'h3 && mild && charge_on_o && batt_above_pq_i)[*6]
    |-> current_target_o == alt_cc_reg && voltage_target_o == alt_cv_reg)
    else $error("alternate targets not applied");
  normal_target_a: assert property (
    (norm && charge_on_o)[*6] |-> current_target_o == cc_reg)
    else $error("normal current target not applied");
  thm_off_a: assert property (
    (ctrl_reg == 2'h1 && charge_on_o)[*6] |-> current_target_o == cc_reg)
    else $error("modified target with monitor off");
  cv_margin_a: assert property (
    (norm && charge_on_o)[*4] |-> 7'(voltage_target_o) + 7'h08 <= 7'(sys_reg))
    else $error("system margin not kept");
  hot_stop_c: cover property (ctrl_reg == 2'h3 && ext && $fell(charge_on_o));
  alt_c: cover property (mild && charge_on_o && current_target_o == alt_cc_reg);
  write_c: cover property (wr ##1 wb_ack_o);
endmodule

bind charger_fault_thermal_fsm charger_fault_thermal_fsm_properties chk (.*);

`default_nettype wire

// [charger_source_model.sv]
// charge source, battery level and thermistor comparator model
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.svh"

module charger_source_model (
  input wire logic clk_i,
  input wire logic plug_i,
  input wire logic charged_i,
  input wire logic [2:0] zone_i,
  output logic chgin_valid_o,
  output logic batt_above_pq_o,
  output logic [3:0] hot_o,
  output logic [3:0] warm_o,
  output logic [3:0] cool_o,
  output logic [3:0] cold_o
);
  // a hot battery is past warm too, a cold one past cool
  always_ff @(posedge clk_i) begin
    chgin_valid_o <= plug_i;
    batt_above_pq_o <= charged_i;
    hot_o <= {4{zone_i == `ZONE_HOT}};
    warm_o <= {4{zone_i == `ZONE_HOT || zone_i == `ZONE_WARM}};
    cool_o <= {4{zone_i == `ZONE_COLD || zone_i == `ZONE_COOL}};
    cold_o <= {4{zone_i == `ZONE_COLD}};
  end
endmodule

`default_nettype wire

// [charger_fault_thermal_fsm_tb.sv]
// self-checking bench for the charger fault and thermal controller
`timescale 1ns/1ps
`default_nettype none
`include "charger_defines.svh"

module charger_fault_thermal_fsm_tb;
  import charger_pkg::*;
  localparam int TK = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic plug = 1'b1;
  logic charged = 1'b0;
  logic at_cv = 1'b0;
  logic iterm = 1'b0;
  logic [2:0] zone = `ZONE_NORMAL;
  logic chgin_valid;
  logic above_pq;
  logic [3:0] hot, warm, cool, cold;
  logic charge_on_o, batt_connect_o, irq_o;
  logic [5:0] current_target_o, voltage_target_o;
  logic [31:0] q;
  int num_errors = 0;
  int comparisons = 0;

  charger_source_model src (.clk_i(clk_i), .plug_i(plug), .charged_i(charged), .zone_i(zone),
    .chgin_valid_o(chgin_valid), .batt_above_pq_o(above_pq), .hot_o(hot), .warm_o(warm),
    .cool_o(cool), .cold_o(cold));
  charger_fault_thermal_fsm #(.TICK_CYCLES(28'(TK))) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .chgin_valid_i(chgin_valid), .batt_above_pq_i(above_pq), .batt_at_cv_i(at_cv),
    .batt_below_iterm_i(iterm), .batt_restart_i(1'b0), .hot_threshold_sel_cmp_i(hot),
    .warm_threshold_sel_cmp_i(warm), .cool_threshold_sel_cmp_i(cool), .cold_threshold_sel_cmp_i(cold),
    .charge_on_o(charge_on_o), .batt_connect_o(batt_connect_o),
    .current_target_o(current_target_o), .voltage_target_o(voltage_target_o), .irq_o(irq_o));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done;
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    cmp(q & m, exp);
  endtask
  task automatic wait_t(input int n);
    repeat (n * TK) @(posedge clk_i);
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (80000) @(posedge clk_i);
    num_errors++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    cmp(32'({charge_on_o, batt_connect_o, irq_o}), 32'h0);
    chk_rd(`TARGET_ADDR, 32'h00003F00, 32'hFFFFFFFF);
    chk_rd(`STATUS_ADDR, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    chk_rd(8'h20, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, `IRQ_MASK_ADDR, 32'h7);
    bus(1'b1, `TARGET_ADDR, 32'h00143F0A);
    bus(1'b1, `ALT_ADDR, 32'h00000705);
    bus(1'b1, `THRESH_ADDR, 32'h000000E4);
    bus(1'b1, `CTRL_ADDR, 32'h3);
    repeat (10) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h31, 32'hFF);
    chk_rd(`IRQ_FLAG_ADDR, 32'h3, 32'h7);
    bus(1'b1, `IRQ_FLAG_ADDR, 32'h7);
    cmp(32'({charge_on_o, irq_o}), 32'h2);
    wait_t(1000);
    zone <= `ZONE_HOT;
    repeat (20) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h5B, 32'hFF);
    cmp(32'({charge_on_o, batt_connect_o, irq_o}), 32'h1);
    wait_t(1000);
    zone <= `ZONE_NORMAL;
    repeat (20) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h31, 32'hFF);
    wait_t(700);
    chk_rd(`STATUS_ADDR, 32'h31, 32'hFF);
    wait_t(150);
    chk_rd(`STATUS_ADDR, 32'h39, 32'hFF);
    cmp(32'({charge_on_o, batt_connect_o}), 32'h0);
    repeat (50) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h09, 32'h0F);
    plug <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h00, 32'h0F);
    cmp(32'({charge_on_o, batt_connect_o}), 32'h1);
    plug <= 1'b1;
    charged <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h02, 32'h0F);
    zone <= `ZONE_WARM;
    repeat (20) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h46, 32'hFF);
    cmp(32'({current_target_o, voltage_target_o}), 32'({6'h05, 6'h07}));
    zone <= `ZONE_NORMAL;
    repeat (20) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h32, 32'hFF);
    cmp(32'({current_target_o, voltage_target_o}), 32'({6'h14, 6'h0A}));
    zone <= `ZONE_COOL;
    repeat (20) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h26, 32'hFF);
    bus(1'b1, `CTRL_ADDR, 32'h1);
    repeat (20) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h02, 32'hFF);
    cmp(32'({current_target_o, voltage_target_o}), 32'({6'h14, 6'h0A}));
    zone <= `ZONE_HOT;
    repeat (20) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h02, 32'hFF);
    zone <= `ZONE_NORMAL;
    bus(1'b1, `TARGET_ADDR, 32'h00143F3C);
    repeat (5) @(posedge clk_i);
    chk_rd(`TARGET_ADDR, 32'h00143F37, 32'hFFFFFFFF);
    cmp(32'(voltage_target_o), 32'h37);
    chk_rd(`IRQ_FLAG_ADDR, 32'h4, 32'h4);
    bus(1'b1, `TARGET_ADDR, 32'h00143F0A);
    bus(1'b1, `CTRL_ADDR, 32'h0);
    repeat (10) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h00, 32'h0F);
    bus(1'b1, `CTRL_ADDR, 32'h5);
    wait_t(10770);
    chk_rd(`STATUS_ADDR, 32'h02, 32'h0F);
    wait_t(60);
    chk_rd(`STATUS_ADDR, 32'h0A, 32'h0F);
    cmp(32'({charge_on_o, batt_connect_o}), 32'h0);
    bus(1'b1, `CTRL_ADDR, 32'h0);
    bus(1'b1, `CTRL_ADDR, 32'h1);
    repeat (10) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h02, 32'h0F);
    at_cv <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h03, 32'h0F);
    iterm <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk_rd(`STATUS_ADDR, 32'h05, 32'h0F);
    test_done();
  end
endmodule

`default_nettype wire
